// [include/aad_pkg.sv]
// Constants and types for the address area decoder.
// Assumes a 32-bit core address and strap pins that are static after reset.
package aad_pkg;

    // ========================================================
    // Address map
    localparam logic [31:0] ADDR_MASK_64   = 32'h03ff_ffff;
    localparam logic [31:0] ADDR_MASK_256  = 32'h0fff_ffff;
    localparam logic [31:0] ROM_BASE_LOW   = 32'h0000_0000;
    localparam logic [31:0] ROM_BASE_HIGH  = 32'h0010_0000;
    localparam logic [31:0] ROM_SIZE       = 32'h0010_0000;
    localparam logic [31:0] RAM_TOP_64     = 32'h03ff_efff;
    localparam logic [31:0] RAM_TOP_256    = 32'h0fff_efff;
    localparam logic [31:0] RAM_SIZE_4K    = 32'h0000_1000;
    localparam logic [31:0] RAM_SIZE_12K   = 32'h0000_3000;
    localparam logic [31:0] RAM_SIZE_28K   = 32'h0000_7000;
    localparam logic [31:0] RAM_SIZE_60K   = 32'h0000_f000;
    localparam logic [31:0] PIO_TOP_64     = 32'h03ff_ffff;
    localparam logic [31:0] PIO_TOP_256    = 32'h0fff_ffff;
    localparam logic [31:0] PIO_SPAN       = 32'h0000_0fff;
    localparam int          PIO_REG_BITS   = 12;
    localparam int          BANK_SHIFT_64  = 23;
    localparam int          BANK_SHIFT_256 = 25;
    localparam int          BANK_COUNT     = 8;

    // ========================================================
    // Entry addresses
    localparam logic [31:0] VEC_RESET      = 32'h0000_0000;
    localparam logic [31:0] VEC_NMI_BASE   = 32'h0000_0010;
    localparam logic [31:0] VEC_TRAP_LOW   = 32'h0000_0040;
    localparam logic [31:0] VEC_TRAP_HIGH  = 32'h0000_0050;
    localparam logic [31:0] VEC_ILLEGAL    = 32'h0000_0060;
    localparam logic [31:0] VEC_INT_BASE   = 32'h0000_0080;
    localparam int          VEC_STEP_SHIFT = 4;

    // Last settle count; the synchronised straps are watched for four cycles before they lock
    localparam logic [3:0]  STRAP_SETTLE   = 4'h3;

    // ========================================================
    // Types
    typedef enum logic [2:0] {
        AAD_SRC_RESET   = 3'h0,
        AAD_SRC_NMI     = 3'h1,
        AAD_SRC_TRAP_LO = 3'h2,
        AAD_SRC_TRAP_HI = 3'h3,
        AAD_SRC_ILLEGAL = 3'h4,
        AAD_SRC_INT     = 3'h5
    } aad_src_t;

    typedef enum logic [3:0] {
        AAD_AREA_NONE = 4'h0,
        AAD_AREA_ROM  = 4'h1,
        AAD_AREA_RAM  = 4'h2,
        AAD_AREA_PIO  = 4'h4,
        AAD_AREA_EXT  = 4'h8
    } aad_area_t;

    typedef enum logic [1:0] {
        AAD_ST_SETTLE = 2'b01,
        AAD_ST_RUN    = 2'b10
    } aad_state_t;

    typedef struct packed {
        logic rom_base_strap;
        logic data_area_size_strap;
        logic ram_size_strap_large;
        logic ram_size_strap_mid;
        logic ram_size_strap_small;
    } aad_straps_t;

endpackage

// [rtl/aad_decoder.sv]
// Address area decoder: classifies core addresses into ROM, RAM,
// peripheral I/O or external bank, and supplies interrupt entry addresses.
// Assumes the core and the peripheral read path share REF_CLK; straps are
// pins from outside and are synchronised first.
`timescale 1ns/100ps

// Operation
// - ROM 1 MB at zero or 1 MB, strap
// - Fixed entry address per source, NMI by VEC_NUM[1:0], table at zero
// - Reset, NMI, trap and illegal opcode entries
// - Maskable n vectors to 0x80 plus 16n
// - RAM top 0x3FFEFFF or 0xFFFEFFF by mode
// - RAM size 60, 28, 12, 4 KB by straps
// - No RAM size beyond 60 KB
// - Peripheral area at top of data space
// - External access asserts its bank select
// - ROM, RAM, peripheral never reach external selects
// - Peripheral select uses low 12 bits only
// - Address bit zero ignored for peripherals
// - Halfword on byte register: upper undefined
// - Size strap low 64 MB, high 256 MB
// - High address bits ignored, images repeat
module aad_decoder #(
    parameter int ADDR_W = 32
) (
    input  wire logic                    REF_CLK,
    input  wire logic                    ARST_N,
    input  wire logic                    CLK_EN,
    input  wire aad_pkg::aad_straps_t    STRAPS,
    input  wire logic                    ACC_VALID,
    input  wire logic [ADDR_W-1:0]       ACC_ADDR,
    input  wire logic                    ACC_WRITE,
    input  wire logic                    ACC_HALF,
    input  wire logic                    PIO_BYTE_REG,
    input  wire logic [15:0]             PIO_RDATA,
    input  wire logic                    VEC_REQ,
    input  wire aad_pkg::aad_src_t       VEC_SRC,
    input  wire logic [5:0]              VEC_NUM,
    output logic                         STRAP_LOCKED,
    output aad_pkg::aad_area_t           AREA_SEL,
    output logic [7:0]                   EXT_BANK_CHIP_SELECTS,
    output logic [11:0]                  PIO_REG_ADDR,
    output logic [1:0]                   PIO_WR_LANES,
    output logic                         PIO_WRITE,
    output logic [15:0]                  PIO_RDATA_OUT,
    output logic                         VEC_VALID,
    output logic [31:0]                  VEC_ADDR
);

    // ========================================================
    // Elaboration checks
    generate
        if (ADDR_W != 32) begin : g_bad_width
            $error("aad_decoder supports only a 32-bit address");
        end
    endgenerate

    // ========================================================
    // Strap synchronisation and lock
    aad_pkg::aad_straps_t strap_meta;
    aad_pkg::aad_straps_t strap_sync;
    aad_pkg::aad_straps_t straps;
    aad_pkg::aad_state_t  state;
    aad_pkg::aad_state_t  next_state;
    logic [3:0]           settle_cnt;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            strap_meta <= '0;
            strap_sync <= '0;
        end else if (CLK_EN) begin
            strap_meta <= STRAPS;
            strap_sync <= strap_meta;
        end
    end

    assign next_state = (state == aad_pkg::AAD_ST_SETTLE &&
                         settle_cnt == aad_pkg::STRAP_SETTLE) ?
                        aad_pkg::AAD_ST_RUN : state;

    // Straps follow the pins only until lock; a late strap change is ignored
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state      <= aad_pkg::AAD_ST_SETTLE;
            settle_cnt <= 4'h0;
            straps     <= '0;
        end else if (CLK_EN) begin
            case (state)
                aad_pkg::AAD_ST_SETTLE: begin
                    settle_cnt <= settle_cnt + 4'h1;
                    straps     <= strap_sync;
                end
                aad_pkg::AAD_ST_RUN: begin
                    settle_cnt <= settle_cnt;
                end
                default: begin
                    settle_cnt <= 4'h0;
                end
            endcase
            state <= next_state;
        end
    end

    wire locked = (state == aad_pkg::AAD_ST_RUN);

    // ========================================================
    // Area decode
    wire        mode256 = straps.data_area_size_strap;
    wire [31:0] addr_mask = mode256 ? aad_pkg::ADDR_MASK_256
                                    : aad_pkg::ADDR_MASK_64;
    wire [31:0] phys = ACC_ADDR & addr_mask;

    wire [31:0] rom_base = straps.rom_base_strap ?
                           aad_pkg::ROM_BASE_HIGH : aad_pkg::ROM_BASE_LOW;
    wire        hit_rom = (phys >= rom_base) &&
                          (phys < rom_base + aad_pkg::ROM_SIZE);

    // Priority encoding leaves no strap code above 60 KB
    wire [31:0] ram_size =
        straps.ram_size_strap_large ? aad_pkg::RAM_SIZE_60K :
        straps.ram_size_strap_mid   ? aad_pkg::RAM_SIZE_28K :
        straps.ram_size_strap_small ? aad_pkg::RAM_SIZE_12K :
                                      aad_pkg::RAM_SIZE_4K;
    wire [31:0] ram_top = mode256 ? aad_pkg::RAM_TOP_256
                                  : aad_pkg::RAM_TOP_64;
    wire [31:0] ram_low = ram_top - ram_size + 32'h0000_0001;
    wire        hit_ram = (phys >= ram_low) && (phys <= ram_top);

    wire [31:0] pio_top = mode256 ? aad_pkg::PIO_TOP_256
                                  : aad_pkg::PIO_TOP_64;
    wire        hit_pio = (phys >= pio_top - aad_pkg::PIO_SPAN) &&
                          (phys <= pio_top);

    // One area only; external is whatever the three fixed areas leave
    wire        hit_ext = !hit_pio && !hit_ram && !hit_rom;
    wire aad_pkg::aad_area_t area_now =
        hit_pio ? aad_pkg::AAD_AREA_PIO :
        hit_ram ? aad_pkg::AAD_AREA_RAM :
        hit_rom ? aad_pkg::AAD_AREA_ROM :
                  aad_pkg::AAD_AREA_EXT;
    wire        acc_ok = ACC_VALID && locked;
    wire aad_pkg::aad_area_t next_area =
        acc_ok ? area_now : aad_pkg::AAD_AREA_NONE;

    // Bank index is the top three bits of the physical image
    wire [31:0] bank_word = mode256 ? (phys >> aad_pkg::BANK_SHIFT_256)
                                    : (phys >> aad_pkg::BANK_SHIFT_64);
    wire [2:0]  bank = bank_word[2:0];
    logic [7:0] next_cs;

    genvar gi;
    generate
        for (gi = 0; gi < aad_pkg::BANK_COUNT; gi++) begin : g_cs
            assign next_cs[gi] = acc_ok && hit_ext &&
                                 (bank == 3'(gi));
        end
    endgenerate

    // ========================================================
    // Peripheral register path
    wire [11:0] next_pio_addr =
        {ACC_ADDR[aad_pkg::PIO_REG_BITS-1:1], 1'b0};
    // Byte registers keep only the low lane on a halfword write
    wire [1:0]  next_lanes = (ACC_HALF && !PIO_BYTE_REG) ? 2'h3
                                                         : 2'h1;
    wire        next_pio_wr = acc_ok && hit_pio && ACC_WRITE;
    // Undefined upper byte is driven as zero to keep reads repeatable
    wire [15:0] next_rdata = PIO_BYTE_REG ? {8'h00, PIO_RDATA[7:0]}
                                          : PIO_RDATA;

    // ========================================================
    // Entry address table
    wire [31:0] int_vec = aad_pkg::VEC_INT_BASE +
                          ({26'h0, VEC_NUM} << aad_pkg::VEC_STEP_SHIFT);
    wire [31:0] nmi_vec = aad_pkg::VEC_NMI_BASE +
                          ({30'h0, VEC_NUM[1:0]} << aad_pkg::VEC_STEP_SHIFT);
    logic [31:0] next_vec;

    always_comb begin
        case (VEC_SRC)
            aad_pkg::AAD_SRC_RESET:   next_vec = aad_pkg::VEC_RESET;
            aad_pkg::AAD_SRC_NMI:     next_vec = nmi_vec;
            aad_pkg::AAD_SRC_TRAP_LO: next_vec = aad_pkg::VEC_TRAP_LOW;
            aad_pkg::AAD_SRC_TRAP_HI: next_vec = aad_pkg::VEC_TRAP_HIGH;
            aad_pkg::AAD_SRC_ILLEGAL: next_vec = aad_pkg::VEC_ILLEGAL;
            aad_pkg::AAD_SRC_INT:     next_vec = int_vec;
            default:                  next_vec = aad_pkg::VEC_RESET;
        endcase
    end

    // ========================================================
    // Output registers
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            STRAP_LOCKED          <= 1'b0;
            AREA_SEL              <= aad_pkg::AAD_AREA_NONE;
            EXT_BANK_CHIP_SELECTS <= 8'h00;
            PIO_REG_ADDR          <= 12'h000;
            PIO_WR_LANES          <= 2'h0;
            PIO_WRITE             <= 1'b0;
            PIO_RDATA_OUT         <= 16'h0000;
            VEC_VALID             <= 1'b0;
            VEC_ADDR              <= aad_pkg::VEC_RESET;
        end else if (CLK_EN) begin
            STRAP_LOCKED          <= locked;
            AREA_SEL              <= next_area;
            EXT_BANK_CHIP_SELECTS <= next_cs;
            PIO_REG_ADDR          <= next_pio_addr;
            PIO_WR_LANES          <= next_lanes;
            PIO_WRITE             <= next_pio_wr;
            PIO_RDATA_OUT         <= next_rdata;
            VEC_VALID             <= VEC_REQ;
            if (VEC_REQ) begin
                VEC_ADDR <= next_vec;
            end
        end
    end

endmodule

// [dv/aad_decoder_checker.sv]
// Assertions for the address area decoder, bound to its top ports.
// Assumes REF_CLK is the only clock and ARST_N resets everything.
`timescale 1ns/100ps
module aad_decoder_checker #(
    parameter int ADDR_W = 32
) (
    input wire logic               REF_CLK,
    input wire logic               ARST_N,
    input wire logic               CLK_EN,
    input wire logic               ACC_VALID,
    input wire logic [ADDR_W-1:0]  ACC_ADDR,
    input wire logic               VEC_REQ,
    input wire aad_pkg::aad_src_t  VEC_SRC,
    input wire logic [5:0]         VEC_NUM,
    input wire logic               STRAP_LOCKED,
    input wire aad_pkg::aad_area_t AREA_SEL,
    input wire logic [7:0]         EXT_BANK_CHIP_SELECTS,
    input wire logic [11:0]        PIO_REG_ADDR,
    input wire logic               VEC_VALID,
    input wire logic [31:0]        VEC_ADDR
);
    // ==========================================================
    // Properties
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    wire take = ACC_VALID && CLK_EN && STRAP_LOCKED;
    wire ext = AREA_SEL == aad_pkg::AAD_AREA_EXT;
    wire int_req = VEC_REQ && CLK_EN && VEC_SRC == aad_pkg::AAD_SRC_INT;
    chk_one_area: assert property (take |=> $onehot(AREA_SEL))
        else $error("access did not select exactly one area");
    chk_idle_area: assert property (
        CLK_EN && !ACC_VALID |=> AREA_SEL == 0)
        else $error("area selected without an access");
    chk_ext_bank: assert property (
        ext |-> $onehot(EXT_BANK_CHIP_SELECTS))
        else $error("external access without one bank select");
    chk_no_ext: assert property (
        !ext |-> EXT_BANK_CHIP_SELECTS == 8'h00)
        else $error("bank select outside the external area");
    chk_pio_index: assert property (CLK_EN |=>
        PIO_REG_ADDR == {$past(ACC_ADDR[11:1]), 1'b0})
        else $error("peripheral index not from low address bits");
    chk_vec_pulse: assert property (
        CLK_EN |=> VEC_VALID == $past(VEC_REQ))
        else $error("entry strobe not one cycle after request");
    chk_vec_int: assert property (int_req |=>
        VEC_ADDR == 32'h00000080 + {22'h000000, $past(VEC_NUM), 4'h0})
        else $error("maskable entry address wrong");
    chk_lock_held: assert property (
        STRAP_LOCKED [*2] |=> STRAP_LOCKED)
        else $error("strap lock dropped while running");
    cover property (take ##1 ext);
    cover property (take ##1 AREA_SEL == aad_pkg::AAD_AREA_PIO);
    cover property (int_req ##1 VEC_VALID);
endmodule

bind aad_decoder aad_decoder_checker #(.ADDR_W(ADDR_W)) u_chk (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .CLK_EN(CLK_EN),
    .ACC_VALID(ACC_VALID), .ACC_ADDR(ACC_ADDR), .VEC_REQ(VEC_REQ),
    .VEC_SRC(VEC_SRC), .VEC_NUM(VEC_NUM), .STRAP_LOCKED(STRAP_LOCKED),
    .AREA_SEL(AREA_SEL), .EXT_BANK_CHIP_SELECTS(EXT_BANK_CHIP_SELECTS),
    .PIO_REG_ADDR(PIO_REG_ADDR), .VEC_VALID(VEC_VALID), .VEC_ADDR(VEC_ADDR));

// [dv/aad_periph_model.sv]
// Peripheral register side of the decoder: width flag and read data.
// Assumes it sees the core address in the access cycle itself.
`timescale 1ns/100ps
module aad_periph_model (
    input  wire logic        ACC_VALID,
    input  wire logic [31:0] ACC_ADDR,
    output logic             PIO_BYTE_REG,
    output logic [15:0]      PIO_RDATA
);
    // ==========================================================
    // Responder
    // Data varies with the address and inverts when idle, so a stale
    // value cannot pass; the upper byte is never zero on byte registers.
    wire [15:0] word = {ACC_ADDR[11:4] ^ 8'h5a, ACC_ADDR[7:0]};
    assign PIO_BYTE_REG = ACC_ADDR[4];
    assign PIO_RDATA = ACC_VALID ? word : ~word;
endmodule

// [dv/address_area_decoder_tb.sv]
// Self-checking bench for the address area decoder.
// Assumes the one-cycle answer and the peripheral model beside it.
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module address_area_decoder_tb;
    logic REF_CLK = 1'b0, ARST_N = 1'b0, ACC_VALID = 1'b0, VEC_REQ = 1'b0;
    logic ACC_WRITE = 1'b0, ACC_HALF = 1'b0, STRAP_LOCKED, VEC_VALID;
    logic PIO_WRITE, PIO_BYTE_REG, t_acc;
    logic [1:0] PIO_WR_LANES;
    logic [5:0] VEC_NUM = 6'h00;
    logic [7:0] cs;
    logic [11:0] PIO_REG_ADDR;
    logic [15:0] PIO_RDATA, PIO_RDATA_OUT;
    logic [31:0] ACC_ADDR = 32'h0, VEC_ADDR, a, r, v, vec_q[$];
    logic [42:0] e, got, acc_q[$];
    aad_pkg::aad_straps_t STRAPS = '0, cfg;
    aad_pkg::aad_straps_t cfgs [4] =
        '{5'h00, 5'h19, 5'h0b, 5'h17};
    aad_pkg::aad_src_t VEC_SRC = aad_pkg::AAD_SRC_RESET;
    aad_pkg::aad_area_t AREA_SEL;
    logic [31:0] dir [14] = '{32'h0, 32'h000fffff, 32'h00100000,
        32'h001fffff, 32'h03ffefff, 32'h03ff0fff, 32'h03ffe000, 32'h03ffdfff,
        32'h03ffc000, 32'hfffff223, 32'h0fffefff, 32'h0fff8fff,
        32'h0ffff7bf, 32'hfc0ffffe};
    int err_count = 0, total_checks = 0;

    aad_decoder dut (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .CLK_EN(1'b1),
        .STRAPS(STRAPS), .ACC_VALID(ACC_VALID), .ACC_ADDR(ACC_ADDR),
        .ACC_WRITE(ACC_WRITE), .ACC_HALF(ACC_HALF), .PIO_BYTE_REG(PIO_BYTE_REG),
        .PIO_RDATA(PIO_RDATA), .VEC_REQ(VEC_REQ), .VEC_SRC(VEC_SRC),
        .VEC_NUM(VEC_NUM), .STRAP_LOCKED(STRAP_LOCKED), .AREA_SEL(AREA_SEL),
        .EXT_BANK_CHIP_SELECTS(cs), .PIO_REG_ADDR(PIO_REG_ADDR),
        .PIO_WR_LANES(PIO_WR_LANES), .PIO_WRITE(PIO_WRITE),
        .PIO_RDATA_OUT(PIO_RDATA_OUT), .VEC_VALID(VEC_VALID),
        .VEC_ADDR(VEC_ADDR));
    aad_periph_model u_periph (.ACC_VALID(ACC_VALID), .ACC_ADDR(ACC_ADDR),
        .PIO_BYTE_REG(PIO_BYTE_REG), .PIO_RDATA(PIO_RDATA));

    // ==========================================================
    // Reference decode and drivers
    function automatic logic [42:0] exp_acc(logic [31:0] a, logic w, logic h);
        logic [31:0] p, rt, rs, rb;
        logic [3:0] ar;
        logic [7:0] cb;
        logic [15:0] rd;
        p = a & (cfg.data_area_size_strap ? 32'h0fffffff
                                          : 32'h03ffffff);
        rt = cfg.data_area_size_strap ? 32'h0fffefff : 32'h03ffefff;
        rs = cfg.ram_size_strap_large ? 32'h0000f000 :
             cfg.ram_size_strap_mid   ? 32'h00007000 :
             cfg.ram_size_strap_small ? 32'h00003000 : 32'h00001000;
        rb = cfg.rom_base_strap ? 32'h00100000 : 32'h00000000;
        rd = {a[11:4] ^ 8'h5a, a[7:0]};
        cb = 8'h00;
        if (p > rt) ar = 4'h4;
        else if (p > rt - rs) ar = 4'h2;
        else if (p >= rb && p < rb + 32'h00100000) ar = 4'h1;
        else begin
            ar = 4'h8;
            cb = 8'h01 << (cfg.data_area_size_strap ? p[27:25]
                                                    : p[25:23]);
        end
        return {ar, cb, ar == 4'h4 ? {a[11:1], 1'b0, w,
            h && !a[4] ? 2'h3 : 2'h1,
            a[4] ? {8'h00, rd[7:0]} : rd} : 31'h0};
    endfunction

    task automatic acc(input logic [31:0] ad, input logic w, input logic h);
        @(posedge REF_CLK);
        ACC_VALID <= 1'b1;
        ACC_ADDR <= ad;
        ACC_WRITE <= w;
        ACC_HALF <= h;
        acc_q.push_back(exp_acc(ad, w, h));
    endtask

    task automatic vec(input aad_pkg::aad_src_t s, input int n, input int x);
        @(posedge REF_CLK);
        ACC_VALID <= 1'b0;
        VEC_REQ <= 1'b1;
        VEC_SRC <= s;
        VEC_NUM <= 6'(n);
        vec_q.push_back(32'(x));
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial forever #20 REF_CLK = ~REF_CLK;
    initial begin
        #400000;
        err_count++;
        results();
    end

    // Notes are taken in order; the taken flag is read before this
    // edge's drive lands, so it matches what the decoder sampled.
    always @(posedge REF_CLK) begin
        t_acc = ACC_VALID;
        #1;
        if (t_acc && acc_q.size() > 0) begin
            e = acc_q.pop_front();
            got = {AREA_SEL, cs, e[42:39] == 4'h4 ? {PIO_REG_ADDR, PIO_WRITE,
                PIO_WR_LANES, PIO_RDATA_OUT} : 31'h0};
            `CHK(got, e)
        end
        if (VEC_VALID) begin
            v = vec_q.size() > 0 ? vec_q.pop_front() : 32'hx;
            `CHK(VEC_ADDR, v)
        end
    end

    initial begin
        void'($urandom(32'hc870));
        foreach (cfgs[c]) begin
            @(posedge REF_CLK);
            ARST_N <= 1'b0;
            VEC_REQ <= 1'b0;
            STRAPS <= cfgs[c];
            cfg = cfgs[c];
            repeat (5) @(posedge REF_CLK);
            ARST_N <= 1'b1;
            for (int n = 0; n < 50 && STRAP_LOCKED !== 1'b1; n++)
                @(posedge REF_CLK);
            if (STRAP_LOCKED !== 1'b1) begin
                err_count++;
                results();
            end
            // Pins move after lock; decode must keep the locked levels
            STRAPS <= ~cfg;
            foreach (dir[i]) begin
                r = $urandom;
                acc(dir[i], r[0], r[1]);
            end
            // Word access to a peripheral is two halfwords, low then high
            acc(32'hfffff804, 1'b1, 1'b1);
            acc(32'hfffff806, 1'b1, 1'b1);
            for (int i = 0; i < 48; i++) begin
                a = $urandom;
                r = $urandom;
                if (i < 8 && cfg.data_area_size_strap) a[27:25] = 3'(i);
                else if (i < 8) a[25:23] = 3'(i);
                else if (i[0]) a[27:16] = 12'hfff;
                acc(a, r[0], r[1]);
            end
            vec(aad_pkg::AAD_SRC_RESET, 0, 'h0);
            for (int k = 0; k < 3; k++) begin
                vec(aad_pkg::AAD_SRC_NMI, k, 'h10 + k * 'h10);
            end
            vec(aad_pkg::AAD_SRC_TRAP_LO, 63, 'h40);
            vec(aad_pkg::AAD_SRC_TRAP_HI, 21, 'h50);
            vec(aad_pkg::AAD_SRC_ILLEGAL, 9, 'h60);
            vec(aad_pkg::aad_src_t'(3'h6), 0, 'h0);
            for (int n = 0; n < 64; n++) begin
                vec(aad_pkg::AAD_SRC_INT, n, 'h80 + n * 'h10);
            end
            @(posedge REF_CLK);
            VEC_REQ <= 1'b0;
            repeat (3) @(posedge REF_CLK);
        end
        `CHK(acc_q.size() + vec_q.size(), 0)
        results();
    end
endmodule
